// >>> hw/can_receive_buffer_regs.sv
`timescale 1ns/1ps
`include "can_rxbuf_consts.svh"
module can_receive_buffer_regs
  import can_rxbuf_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Frame from protocol engine
  input wire logic rx_valid_i,
  input wire logic rx_ok_i,
  input wire logic rx_ext_i,
  input wire logic rx_rtr_i,
  input wire logic [28:0] rx_ident_i,
  input wire logic [3:0] rx_len_i,
  input wire logic rx_hit_i,
  input wire logic [4:0] rx_hit_idx_i,
  input wire logic rx_hit_ext_en_i,
  // Status
  output logic buffer0_receive_irq_flag_o,
  output logic rx_dropped_o
);

  // Per-buffer and shared stored state
  logic [1:0] buffer_full_flag;
  logic [1:0] mode_hi;
  logic [1:0] mode_lo;
  logic overflow_to_second_buffer_en;
  logic [1:0] remote_request_seen;
  logic [1:0] extended_frame_flag;
  logic [28:0] ident [2];
  logic [3:0] payload_length_code [2];
  logic [4:0] matching_filter_index [2];
  logic [1:0] op_mode;
  logic irq0;
  logic dropped;
  logic [1:0] next_full;
  logic [1:0] next_mode_hi;
  logic [1:0] next_mode_lo;
  logic next_dben;
  logic [1:0] next_rtr;
  logic [1:0] next_ext;
  logic [28:0] next_ident [2];
  logic [3:0] next_len [2];
  logic [4:0] next_hit [2];
  logic [1:0] next_op_mode;
  logic next_irq0;
  logic next_dropped;
  logic [31:0] next_dat;
  logic next_ack;
  logic next_err;

  op_mode_t opm;
  assign opm = op_mode_t'(op_mode);

  // Acceptance decision for buffer n under the current mode settings
  function automatic logic accepts(input logic hi, input logic lo, input op_mode_t m,
                                   input logic ok, input logic hit, input logic ext,
                                   input logic fext);
    logic a;
    a = 1'b0;
    if (m == OP_MODE0) begin
      case (accept_mode_t'({hi, lo}))
        ACC_EVERYTHING: a = 1'b1;
        ACC_EXT_ONLY: a = ok && hit && ext && fext;
        ACC_STD_ONLY: a = ok && hit && !ext && !fext;
        ACC_ALL_VALID: a = ok && hit && (ext == fext);
        default: a = 1'b0;
      endcase
    end else begin
      a = hi ? 1'b1 : (ok && hit);
    end
    return a;
  endfunction : accepts

  // Control register image for buffer n
  function automatic logic [7:0] ctrl_image(input int n, input op_mode_t m, input logic full,
                                            input logic hi, input logic lo, input logic rtr,
                                            input logic dben, input logic [4:0] hit);
    logic [7:0] v;
    v = 8'h00;
    v[`RB_FULL_BIT] = full;
    v[`RB_MODE_HI_BIT] = hi;
    if (m == OP_MODE0) begin
      v[`RB_MODE_LO_BIT] = lo;
      v[`RB_RTR_M0_BIT] = rtr;
      if (n == 0) begin
        v[`RB_DBEN_BIT] = dben;
        v[`RB_JUMP_OFFSET_SELECT_BIT] = dben;
        v[0] = hit[0];
      end else begin
        v[2:0] = hit[2:0];
      end
      // Bit 4 left zero in mode 0
    end else begin
      v[`RB_RTR_M12_BIT] = rtr;
      v[4:0] = hit;
    end
    return v;
  endfunction : ctrl_image

  logic acc0;
  logic acc1;
  logic to0;
  logic to1;
  logic req;
  logic [3:0] idx;
  logic [1:0] sel;

  always_comb begin
    acc0 = accepts(mode_hi[0], mode_lo[0], opm, rx_ok_i, rx_hit_i, rx_ext_i, rx_hit_ext_en_i);
    acc1 = accepts(mode_hi[1], mode_lo[1], opm, rx_ok_i, rx_hit_i, rx_ext_i, rx_hit_ext_en_i);
    // In mode 0 filters 0/1 belong to buffer 0, 2 and above to buffer 1
    if (opm == OP_MODE0) begin
      to0 = rx_valid_i && (mode_hi[0] && mode_lo[0] ? 1'b1 : rx_hit_idx_i < 5'h02) && acc0;
      // One frame lands in one buffer only, even when both would accept it
      to1 = rx_valid_i && !to0 && ((mode_hi[1] && mode_lo[1]) ? 1'b1 : (rx_hit_idx_i >= 5'h02)) && acc1;
      if (to0 && buffer_full_flag[0] && overflow_to_second_buffer_en) begin
        to1 = 1'b1;
        to0 = 1'b0;
      end
    end else begin
      to0 = rx_valid_i && acc0;
      to1 = rx_valid_i && !to0 && acc1;
    end
    if (to0 && buffer_full_flag[0]) begin
      to0 = 1'b0;
    end
    if (to1 && buffer_full_flag[1]) begin
      to1 = 1'b0;
    end
  end

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign idx = wb_adr_i[5:2];
  assign sel = {to1, to0};

  always_comb begin
    next_full = buffer_full_flag;
    next_mode_hi = mode_hi;
    next_mode_lo = mode_lo;
    next_dben = overflow_to_second_buffer_en;
    next_rtr = remote_request_seen;
    next_ext = extended_frame_flag;
    next_ident = ident;
    next_len = payload_length_code;
    next_hit = matching_filter_index;
    next_op_mode = op_mode;
    next_irq0 = irq0;
    next_dropped = dropped;
    next_dat = 32'h0000_0000;
    next_ack = 1'b0;
    next_err = 1'b0;
    if (req) begin
      next_ack = idx <= `RB_IDX_IRQ;
      next_err = idx > `RB_IDX_IRQ;
      if (wb_we_i && wb_sel_i[0]) begin
        case (idx)
          `RB_IDX_CTRL0, `RB_IDX_CTRL1: begin
            // Full flag is clear-only from software
            if (!wb_dat_i[`RB_FULL_BIT]) begin
              next_full[idx[0]] = 1'b0;
            end
            next_mode_hi[idx[0]] = wb_dat_i[`RB_MODE_HI_BIT];
            if (opm == OP_MODE0) begin
              next_mode_lo[idx[0]] = wb_dat_i[`RB_MODE_LO_BIT];
              if (idx == `RB_IDX_CTRL0) begin
                next_dben = wb_dat_i[`RB_DBEN_BIT];
              end
            end
          end
          `RB_IDX_MODE: next_op_mode = wb_dat_i[1:0];
          `RB_IDX_IRQ: begin
            if (wb_dat_i[0]) begin
              next_irq0 = 1'b0;
            end
            if (wb_dat_i[1]) begin
              next_dropped = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
      case (idx)
        `RB_IDX_CTRL0: next_dat[7:0] = ctrl_image(0, opm, buffer_full_flag[0], mode_hi[0], mode_lo[0],
                                                 remote_request_seen[0], overflow_to_second_buffer_en,
                                                 matching_filter_index[0]);
        `RB_IDX_CTRL1: next_dat[7:0] = ctrl_image(1, opm, buffer_full_flag[1], mode_hi[1], mode_lo[1],
                                                 remote_request_seen[1], 1'b0, matching_filter_index[1]);
        `RB_IDX_IDH0, `RB_IDX_IDH1: begin
          next_dat[7:0] = extended_frame_flag[idx[2]] ? ident[idx[2]][28:21] : ident[idx[2]][10:3];
        end
        `RB_IDX_IDL0, `RB_IDX_IDL1: begin
          next_dat[7:5] = extended_frame_flag[idx[2]] ? ident[idx[2]][20:18] : ident[idx[2]][2:0];
          next_dat[`RB_SRR_BIT] = !extended_frame_flag[idx[2]] && remote_request_seen[idx[2]];
          next_dat[`RB_EXT_BIT] = extended_frame_flag[idx[2]];
          next_dat[1:0] = extended_frame_flag[idx[2]] ? ident[idx[2]][17:16] : 2'b00;
        end
        `RB_IDX_EIDH0: next_dat[7:0] = extended_frame_flag[0] ? ident[0][15:8] : 8'h00;
        `RB_IDX_EIDH1: next_dat[7:0] = extended_frame_flag[1] ? ident[1][15:8] : 8'h00;
        `RB_IDX_EIDL0: next_dat[7:0] = extended_frame_flag[0] ? ident[0][7:0] : 8'h00;
        `RB_IDX_EIDL1: next_dat[7:0] = extended_frame_flag[1] ? ident[1][7:0] : 8'h00;
        `RB_IDX_LEN0: next_dat[3:0] = payload_length_code[0];
        `RB_IDX_LEN1: next_dat[3:0] = payload_length_code[1];
        `RB_IDX_MODE: next_dat[1:0] = op_mode;
        `RB_IDX_IRQ: next_dat[1:0] = {dropped, irq0};
        default: next_dat = 32'h0000_0000;
      endcase
    end
    // Message store wins over a same-cycle software clear
    for (int n = 0; n < 2; n++) begin
      if (sel[n]) begin
        next_full[n] = 1'b1;
        next_rtr[n] = rx_rtr_i;
        next_ext[n] = rx_ext_i;
        next_ident[n] = rx_ext_i ? rx_ident_i : {18'h00000, rx_ident_i[10:0]};
        next_len[n] = (rx_len_i > `RB_LEN_MAX) ? `RB_LEN_MAX : rx_len_i;
        next_hit[n] = rx_hit_idx_i;
      end
    end
    if (sel[0] || next_full[0]) begin
      next_irq0 = 1'b1;
    end
    if (rx_valid_i && (acc0 || acc1) && sel == 2'b00) begin
      next_dropped = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buffer_full_flag <= 2'b00;
      mode_hi <= 2'b00;
      mode_lo <= 2'b00;
      overflow_to_second_buffer_en <= 1'b0;
      remote_request_seen <= 2'b00;
      extended_frame_flag <= 2'b00;
      ident <= '{default: 29'h0000_0000};
      payload_length_code <= '{default: 4'h0};
      matching_filter_index <= '{default: 5'h00};
      op_mode <= 2'b00;
      irq0 <= 1'b0;
      dropped <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      buffer_full_flag <= next_full;
      mode_hi <= next_mode_hi;
      mode_lo <= next_mode_lo;
      overflow_to_second_buffer_en <= next_dben;
      remote_request_seen <= next_rtr;
      extended_frame_flag <= next_ext;
      ident <= next_ident;
      payload_length_code <= next_len;
      matching_filter_index <= next_hit;
      op_mode <= next_op_mode;
      irq0 <= next_irq0;
      dropped <= next_dropped;
      wb_dat_o <= next_dat;
      wb_ack_o <= next_ack;
      wb_err_o <= next_err;
    end
  end

  assign buffer0_receive_irq_flag_o = irq0;
  assign rx_dropped_o = dropped;

endmodule : can_receive_buffer_regs

// >>> hw/can_rxbuf_consts.svh
`ifndef CAN_RXBUF_CONSTS_SVH
`define CAN_RXBUF_CONSTS_SVH
// Word indices on the register bus (byte address = index * 4)
`define RB_IDX_CTRL0 4'h0
`define RB_IDX_CTRL1 4'h1
`define RB_IDX_IDH0 4'h2
`define RB_IDX_IDL0 4'h3
`define RB_IDX_EIDH0 4'h4
`define RB_IDX_EIDL0 4'h5
`define RB_IDX_IDH1 4'h6
`define RB_IDX_IDL1 4'h7
`define RB_IDX_EIDH1 4'h8
`define RB_IDX_EIDL1 4'h9
`define RB_IDX_LEN0 4'ha
`define RB_IDX_LEN1 4'hb
`define RB_IDX_MODE 4'hc
`define RB_IDX_IRQ 4'hd
// Control register field positions
`define RB_FULL_BIT 7
`define RB_MODE_HI_BIT 6
`define RB_MODE_LO_BIT 5
`define RB_RTR_M0_BIT 3
`define RB_RTR_M12_BIT 5
`define RB_DBEN_BIT 2
`define RB_JUMP_OFFSET_SELECT_BIT 1
// Identifier low field positions, then the length clamp and the control reset value
`define RB_EXT_BIT 3
`define RB_SRR_BIT 4
`define RB_LEN_MAX 4'h8
`define RB_CTRL_RESET 8'h00
`endif

// >>> hw/can_rxbuf_pkg.sv
package can_rxbuf_pkg;
  typedef enum logic [1:0] {
    ACC_ALL_VALID,
    ACC_STD_ONLY,
    ACC_EXT_ONLY,
    ACC_EVERYTHING
  } accept_mode_t;
  typedef enum logic [1:0] {
    OP_MODE0,
    OP_MODE1,
    OP_MODE2,
    OP_MODE_RSVD
  } op_mode_t;
endpackage : can_rxbuf_pkg

// >>> verification/can_receive_buffer_regs_props.sv
`timescale 1ns/1ps
module can_receive_buffer_regs_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // Frame and status
  input wire logic rx_valid_i,
  input wire logic buffer0_receive_irq_flag_o,
  input wire logic rx_dropped_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic take;
  logic clr;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign clr = take && wb_we_i && wb_adr_i[5:2] == 4'hd && wb_sel_i[0];
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  answer_next_a: assert property (take |=> wb_ack_o ^ wb_err_o) else $error("no single answer");
  err_range_a: assert property (take && wb_adr_i[5:2] > 4'hd |=> wb_err_o) else $error("no error");
  no_spurious_a: assert property (!take |=> !wb_ack_o && !wb_err_o) else $error("stray answer");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data set");
  idlow_gap_a: assert property (take && !wb_we_i && wb_adr_i[5:2] inside {4'h3, 4'h7} |=> !wb_dat_o[2])
    else $error("gap bit set");
  irq_hold_a: assert property (buffer0_receive_irq_flag_o && !(clr && wb_dat_i[0]) |=> buffer0_receive_irq_flag_o)
    else $error("irq lost");
  drop_hold_a: assert property (rx_dropped_o && !(clr && wb_dat_i[1]) |=> rx_dropped_o) else $error("drop lost");
  drop_cause_a: assert property ($rose(rx_dropped_o) |-> $past(rx_valid_i)) else $error("drop w/o frame");
  cover property (wb_err_o);
  cover property ($rose(rx_dropped_o));
  cover property ($rose(buffer0_receive_irq_flag_o));
endmodule : can_receive_buffer_regs_props

// >>> verification/can_frame_source.sv
`timescale 1ns/1ps
module can_frame_source (
  // Clock
  input wire logic clk_i,
  // Frame towards the buffers
  output logic rx_valid_o,
  output logic rx_ok_o,
  output logic rx_ext_o,
  output logic rx_rtr_o,
  output logic [28:0] rx_ident_o,
  output logic [3:0] rx_len_o,
  output logic rx_hit_o,
  output logic [4:0] rx_hit_idx_o,
  output logic rx_hit_ext_en_o
);
  logic [42:0] f = 43'h0;
  initial rx_valid_o = 1'h0;
  assign {rx_ok_o, rx_ext_o, rx_rtr_o, rx_ident_o, rx_len_o, rx_hit_o, rx_hit_idx_o, rx_hit_ext_en_o} = f;
  task automatic send(input logic [42:0] v);
    @(posedge clk_i);
    rx_valid_o <= 1'h1;
    f <= v;
    @(posedge clk_i);
    rx_valid_o <= 1'h0;
    // Fields are stale after the pulse; flip them so nothing leans on them
    f <= ~v;
  endtask : send
endmodule : can_frame_source

// >>> verification/can_receive_buffer_regs_tb.sv
`timescale 1ns/1ps
module can_receive_buffer_regs_tb;
  import can_rxbuf_pkg::*;
  logic clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [5:0] wb_adr_i = 6'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, seed = 32'hfdcb, r;
  logic wb_ack_o, wb_err_o, rx_valid_i, rx_ok_i, rx_ext_i, rx_rtr_i, rx_hit_i, rx_hit_ext_en_i, irq, drop, ext, rtr;
  logic [28:0] rx_ident_i, id;
  logic [3:0] rx_len_i, ln;
  logic [4:0] rx_hit_idx_i;
  logic [7:0] q;
  int fail_count = 0, tests_run = 0, cycles = 0;
  always #2.5 clk_i = ~clk_i;
  can_receive_buffer_regs u_can_receive_buffer_regs (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .rx_valid_i(rx_valid_i), .rx_ok_i(rx_ok_i),
    .rx_ext_i(rx_ext_i), .rx_rtr_i(rx_rtr_i), .rx_ident_i(rx_ident_i), .rx_len_i(rx_len_i), .rx_hit_i(rx_hit_i),
    .rx_hit_idx_i(rx_hit_idx_i), .rx_hit_ext_en_i(rx_hit_ext_en_i), .buffer0_receive_irq_flag_o(irq),
    .rx_dropped_o(drop));
  can_frame_source u_can_frame_source (.clk_i(clk_i), .rx_valid_o(rx_valid_i), .rx_ok_o(rx_ok_i),
    .rx_ext_o(rx_ext_i), .rx_rtr_o(rx_rtr_i), .rx_ident_o(rx_ident_i), .rx_len_o(rx_len_i), .rx_hit_o(rx_hit_i),
    .rx_hit_idx_o(rx_hit_idx_i), .rx_hit_ext_en_o(rx_hit_ext_en_i));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic wb(input logic we, input logic [3:0] i, input logic [7:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, i, 2'h0, 24'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1);
    q = wb_err_o ? 8'hee : wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask : wb
  task automatic chk(input string nm, input logic [3:0] i, input logic [7:0] e, m);
    wb(1'h0, i, 8'h0);
    tests_run++;
    if (((q ^ e) & m) !== 8'h0) begin
      $display("unexpected %s: expected %h, seen %h", nm, e & m, q & m);
      fail_count++;
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    for (int i = 0; i < 14; i++) chk("reset", i[3:0], 8'h0, 8'hff);
    chk("unmapped", 4'hf, 8'hee, 8'hff);
    $display("test reset done");
    for (int n = 0; n < 6; n++) begin
      wb(1'h1, 4'h0, 8'h60);
      r = rnd();
      id = 29'(rnd());
      {ext, rtr, ln} = r[5:0];
      // Accept-all mode: error flag and filter hit are random on purpose
      u_can_frame_source.send({r[6], ext, rtr, id, ln, r[7], r[12:8], r[13]});
      chk("ctrl0", 4'h0, {4'he, rtr, 3'h0}, 8'hfe);
      chk("idhigh", 4'h2, ext ? id[28:21] : id[10:3], 8'hff);
      chk("idlow", 4'h3, ext ? {id[20:18], 2'h1, 1'h0, id[17:16]} : {id[2:0], rtr, 4'h0}, ext ? 8'hff : 8'hf8);
      if (ext) chk("extid", 4'h4, id[15:8], 8'hff);
      chk("len", 4'ha, (ln > 4'h8) ? 8'h8 : {4'h0, ln}, 8'hff);
      // Filter index 0 keeps this frame away from buffer 1, so it must be dropped
      u_can_frame_source.send({~{r[6], ext, rtr, id, ln, r[7]}, 5'h00, ~r[13]});
      chk("held", 4'h2, ext ? id[28:21] : id[10:3], 8'hff);
      chk("irq", 4'hd, 8'h3, 8'h3);
      wb(1'h1, 4'hd, 8'h3);
      chk("irq again", 4'hd, 8'h1, 8'h3);
      wb(1'h1, 4'h0, 8'h60);
      wb(1'h1, 4'hd, 8'h1);
      chk("irq clear", 4'hd, 8'h0, 8'h3);
    end
    $display("test random frames done");
    wb(1'h1, 4'h0, 8'h04);
    chk("dben", 4'h0, 8'h06, 8'hf6);
    repeat (2) u_can_frame_source.send({3'h4, 29'h123, 4'h2, 1'h1, 5'h1, 1'h0});
    chk("buf0 hit", 4'h0, 8'h87, 8'hff);
    chk("buf1 hit", 4'h1, 8'h81, 8'hff);
    wb(1'h1, 4'h0, 8'h20);
    wb(1'h1, 4'h1, 8'h0);
    u_can_frame_source.send({3'h6, 29'h1abcdef0, 4'h8, 1'h1, 5'h0, 1'h1});
    chk("std only", 4'h0, 8'h21, 8'hff);
    wb(1'h1, 4'h0, 8'h40);
    u_can_frame_source.send({3'h6, 29'h1abcdef0, 4'h8, 1'h1, 5'h0, 1'h1});
    chk("ext only", 4'h0, 8'hc0, 8'hff);
    wb(1'h1, 4'h0, 8'h0);
    u_can_frame_source.send({3'h4, 29'h5a5, 4'h1, 1'h1, 5'h0, 1'h0});
    chk("all valid", 4'h0, 8'h80, 8'hff);
    wb(1'h1, 4'h0, 8'h0);
    wb(1'h1, 4'hc, 8'h1);
    u_can_frame_source.send({3'h7, 29'h0, 4'h0, 1'h1, 5'hd, 1'h1});
    chk("mode1 ctrl0", 4'h0, 8'had, 8'hff);
    $display("test modes done");
    wrap_up();
  end
endmodule : can_receive_buffer_regs_tb
bind can_receive_buffer_regs can_receive_buffer_regs_props u_props (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .rx_valid_i(rx_valid_i),
  .buffer0_receive_irq_flag_o(buffer0_receive_irq_flag_o), .rx_dropped_o(rx_dropped_o));
